// ### dhl_pkg.sv
package dhl_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int DHL_NUM_CH = 4;
	localparam int DHL_NUM_BINS = 10;
	localparam int DHL_NUM_SRC = 18;
	localparam int DHL_SMP_W = 16;
	localparam logic [19:0] DHL_BIN_SCALE = 20'h0000a;
	localparam logic [15:0] DHL_MAX_FLOOR = 16'h000a;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] DHL_OFF_STATE = 12'h000;
	localparam logic [11:0] DHL_OFF_SRC0 = 12'h004;
	localparam logic [11:0] DHL_OFF_PERIOD = 12'h014;
	localparam logic [11:0] DHL_OFF_MAX0 = 12'h018;
	localparam logic [11:0] DHL_OFF_PEAK0 = 12'h028;
	localparam logic [11:0] DHL_OFF_BIN0 = 12'h040;
	localparam logic [11:0] DHL_CH_STRIDE = 12'h040;
	localparam logic [11:0] DHL_OFF_END = 12'h140;

	// ------------------------------------------------------------
	// state control codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DHL_ST_STOP = 3'h0,
		DHL_ST_START = 3'h1,
		DHL_ST_ALWAYS = 3'h2,
		DHL_ST_RESET = 3'h3,
		DHL_ST_CLEAR = 3'h4,
		DHL_ST_ERROR = 3'h5
	} dhl_state_t;

	// ------------------------------------------------------------
	// sample period codes and times
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DHL_PER_200MS = 2'h0,
		DHL_PER_1S = 2'h1,
		DHL_PER_2S = 2'h2,
		DHL_PER_5S = 2'h3
	} dhl_period_t;

	localparam logic [4:0] DHL_SRC_OFF = 5'h00;
	localparam int DHL_CLK_KHZ = 250000;
	localparam int DHL_T0_MS = 200;
	localparam int DHL_T1_MS = 1000;
	localparam int DHL_T2_MS = 2000;
	localparam int DHL_T3_MS = 5000;
	localparam int DHL_T0_CYC = DHL_T0_MS * DHL_CLK_KHZ;
	localparam int DHL_T1_CYC = DHL_T1_MS * DHL_CLK_KHZ;
	localparam int DHL_T2_CYC = DHL_T2_MS * DHL_CLK_KHZ;
	localparam int DHL_T3_CYC = DHL_T3_MS * DHL_CLK_KHZ;
endpackage

// ### dhl_tick.sv
`timescale 1ns/1ns
module dhl_tick import dhl_pkg::*; #(
	parameter int T0_CYC = DHL_T0_CYC,
	parameter int T1_CYC = DHL_T1_CYC,
	parameter int T2_CYC = DHL_T2_CYC,
	parameter int T3_CYC = DHL_T3_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic [1:0] period_sel,
	input wire logic restart,
	// common sample strobe
	output logic tick
);
	logic [31:0] cnt_r;
	logic [31:0] limit;

	// terminal count of the selected period
	always_comb begin
		unique case (dhl_period_t'(period_sel))
			DHL_PER_200MS: limit = 32'(T0_CYC - 1);
			DHL_PER_1S: limit = 32'(T1_CYC - 1);
			DHL_PER_2S: limit = 32'(T2_CYC - 1);
			DHL_PER_5S: limit = 32'(T3_CYC - 1);
		endcase
	end

	assign tick = (cnt_r >= limit);

	// free counter, restarted so a new period starts a full interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
		end else if (restart || tick) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
endmodule

// ### dhl_channel.sv
`timescale 1ns/1ns
module dhl_channel import dhl_pkg::*; #(
	parameter int BIN_W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sampling
	input wire logic stb,
	input wire logic [15:0] sample,
	input wire logic [15:0] max_val,
	input wire logic clr,
	// readback
	input wire logic [3:0] rd_bin,
	output logic [BIN_W-1:0] bin_cnt,
	output logic [15:0] peak
);
	logic [BIN_W-1:0] bins_r [DHL_NUM_BINS];
	logic [15:0] peak_r;
	logic [3:0] idx;
	logic in_range;
	logic inc;

	// bin index by comparing ten times the sample with multiples of max
	function automatic logic [3:0] bin_of(input logic [15:0] s, input logic [15:0] m);
		logic [19:0] s10;
		logic [3:0] r;
		s10 = {4'h0, s} * DHL_BIN_SCALE;
		r = 4'h0;
		for (int k = 1; k < DHL_NUM_BINS; k++) begin
			if (s10 >= 20'(k) * {4'h0, m}) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction

	assign idx = bin_of(sample, max_val);
	assign in_range = (sample <= max_val);
	assign inc = stb && in_range;
	assign bin_cnt = (rd_bin < 4'(DHL_NUM_BINS)) ? bins_r[rd_bin] : '0;
	assign peak = peak_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int b = 0; b < DHL_NUM_BINS; b++) bins_r[b] <= '0;
		end else if (clr) begin
			for (int b = 0; b < DHL_NUM_BINS; b++) bins_r[b] <= '0;
		end else if (inc && (bins_r[idx] != '1)) begin
			bins_r[idx] <= bins_r[idx] + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peak_r <= 16'h0;
		end else if (clr) begin
			peak_r <= 16'h0;
		end else if (stb && (sample > peak_r)) begin
			peak_r <= sample;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_top_bin_place: assert property (stb && sample == max_val |-> idx == 4'h9)
		else $error("sample at max not in top bin");
	a_over_max_skip: assert property (stb && sample > max_val |-> !inc)
		else $error("over-range sample counted");
	a_bin_saturate: assert property (!clr && bins_r[idx] == '1 && inc |=> bins_r[$past(idx)] == '1)
		else $error("bin counter wrapped");
	a_peak_rises: assert property (stb && !clr && sample > peak_r |=> peak_r == $past(sample))
		else $error("peak not captured");
endmodule

// ### dhl_logger.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
// Function
// - four independent channels, each with its own source, logged together
// - every active channel samples on one shared sample tick
// - each channel accumulates ten bins, each ten percent of its maximum
// - a write that changes configuration clears all accumulated data
// - stop disables, start logs while motor runs, always logs every tick
// - reset command restores configuration and data; clear erases data and the sticky error only
// - a fault during logging shows the error code in state readback
// - selector picks a listed source or disabled; disabled accumulates nothing
// - each active channel holds its largest sample since last clear
// - samples above the channel maximum go into no bin
// - sample period 200 ms, 1 s, 2 s or 5 s, default 1 s
// - each channel has its own maximum between 10 and 65535
module dhl_logger import dhl_pkg::*; #(
	parameter int BIN_W = 16,
	parameter int T0_CYC = DHL_T0_CYC,
	parameter int T1_CYC = DHL_T1_CYC,
	parameter int T2_CYC = DHL_T2_CYC,
	parameter int T3_CYC = DHL_T3_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// drive measurement side
	input wire logic [DHL_NUM_SRC*DHL_SMP_W-1:0] src_data,
	input wire logic [DHL_NUM_CH*16-1:0] ch_max,
	input wire logic meas_fault,
	// motor running indication pin
	input wire logic motor_run
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [2:0] mode_r;
	logic [2:0] mode_nxt;
	logic err_r;
	logic [4:0] src_r [DHL_NUM_CH];
	logic [1:0] period_r;
	logic [15:0] max_prev_r [DHL_NUM_CH];
	logic [1:0] run_sync_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr;
	logic wr_state;
	logic [DHL_NUM_CH-1:0] wr_src;
	logic wr_period;
	logic cfg_chg;
	logic max_chg;
	logic data_clr;
	logic log_active;
	logic tick;
	logic [DHL_NUM_CH-1:0] ch_en;
	logic [15:0] ch_sample [DHL_NUM_CH];
	logic [15:0] ch_maxv [DHL_NUM_CH];
	logic [BIN_W-1:0] ch_bin [DHL_NUM_CH];
	logic [15:0] ch_peak [DHL_NUM_CH];
	logic [3:0] rd_bin;
	logic [11:0] bin_rel;
	logic [1:0] rd_ch;
	logic run_s;
	logic [2:0] wcode;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// pick one quantity out of the flat source bus, zero when disabled
	function automatic logic [15:0] pick_src(input logic [4:0] sel,
		input logic [DHL_NUM_SRC*DHL_SMP_W-1:0] bus);
		logic [15:0] v;
		v = 16'h0;
		for (int s = 1; s <= DHL_NUM_SRC; s++) begin
			if (sel == 5'(s)) begin
				v = bus[(s-1)*DHL_SMP_W +: DHL_SMP_W];
			end
		end
		return v;
	endfunction

	// a maximum below the floor would make bins meaningless, so lift it
	function automatic logic [15:0] eff_max(input logic [15:0] m);
		return (m < DHL_MAX_FLOOR) ? DHL_MAX_FLOOR : m;
	endfunction

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero wait state: read data is latched in the setup phase
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign wr_state = wr && (paddr == DHL_OFF_STATE);
	assign wr_period = wr && (paddr == DHL_OFF_PERIOD);
	assign wcode = pwdata[2:0];
	assign prdata = prdata_r;
	assign pslverr = psel && penable && !rd_hit;

	// per-channel selector strobes
	always_comb begin
		for (int c = 0; c < DHL_NUM_CH; c++) begin
			wr_src[c] = wr && (paddr == DHL_OFF_SRC0 + 12'(4 * c));
		end
	end

	// bin window address split
	assign bin_rel = paddr - DHL_OFF_BIN0;
	assign rd_ch = bin_rel[7:6];
	assign rd_bin = bin_rel[5:2];

	// read mux; unmapped addresses answer with an error
	always_comb begin
		rd_data = 32'h0;
		rd_hit = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (paddr == DHL_OFF_STATE) begin
			rd_hit = 1'b1;
			rd_data = {29'h0, err_r ? 3'(DHL_ST_ERROR) : mode_r};
		end else if (paddr == DHL_OFF_PERIOD) begin
			rd_hit = 1'b1;
			rd_data = {30'h0, period_r};
		end else if (paddr >= DHL_OFF_BIN0 && paddr < DHL_OFF_END) begin
			rd_hit = (rd_bin < 4'(DHL_NUM_BINS));
			rd_data = 32'(ch_bin[rd_ch]);
		end else begin
			for (int c = 0; c < DHL_NUM_CH; c++) begin
				if (paddr == DHL_OFF_SRC0 + 12'(4 * c)) begin
					rd_hit = 1'b1;
					rd_data = {27'h0, src_r[c]};
				end
				if (paddr == DHL_OFF_MAX0 + 12'(4 * c)) begin
					rd_hit = 1'b1;
					rd_data = {16'h0, ch_maxv[c]};
				end
				if (paddr == DHL_OFF_PEAK0 + 12'(4 * c)) begin
					rd_hit = 1'b1;
					rd_data = {16'h0, ch_peak[c]};
				end
			end
		end
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_data;
		end
	end

	// ------------------------------------------------------------
	// state control
	// ------------------------------------------------------------
	// mode stored; reset command falls back to stop
	always_comb begin
		mode_nxt = mode_r;
		if (wr_state) begin
			unique case (wcode)
				3'(DHL_ST_STOP), 3'(DHL_ST_START), 3'(DHL_ST_ALWAYS): mode_nxt = wcode;
				3'(DHL_ST_RESET): mode_nxt = 3'(DHL_ST_STOP);
				default: mode_nxt = mode_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= 3'(DHL_ST_STOP);
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// sticky error; while set it halts logging, so a fault cannot hold it in the clearing cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_r <= 1'b0;
		end else if (meas_fault && log_active) begin
			err_r <= 1'b1;
		end else if (wr_state) begin
			err_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// selectors; codes beyond the list are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < DHL_NUM_CH; c++) src_r[c] <= DHL_SRC_OFF;
		end else if (wr_state && wcode == 3'(DHL_ST_RESET)) begin
			for (int c = 0; c < DHL_NUM_CH; c++) src_r[c] <= DHL_SRC_OFF;
		end else begin
			for (int c = 0; c < DHL_NUM_CH; c++) begin
				if (wr_src[c] && pwdata[31:5] == 27'h0
					&& pwdata[4:0] <= 5'(DHL_NUM_SRC)) begin
					src_r[c] <= pwdata[4:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_r <= 2'(DHL_PER_1S);
		end else if (wr_state && wcode == 3'(DHL_ST_RESET)) begin
			period_r <= 2'(DHL_PER_1S);
		end else if (wr_period && pwdata[31:2] == 30'h0) begin
			period_r <= pwdata[1:0];
		end
	end

	// per-channel maximum, history kept to spot changes
	always_comb begin
		for (int c = 0; c < DHL_NUM_CH; c++) begin
			ch_maxv[c] = eff_max(ch_max[c*16 +: 16]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < DHL_NUM_CH; c++) max_prev_r[c] <= DHL_MAX_FLOOR;
		end else begin
			for (int c = 0; c < DHL_NUM_CH; c++) max_prev_r[c] <= ch_maxv[c];
		end
	end

	always_comb begin
		cfg_chg = wr_period && pwdata[31:2] == 30'h0 && pwdata[1:0] != period_r;
		max_chg = 1'b0;
		for (int c = 0; c < DHL_NUM_CH; c++) begin
			if (wr_src[c] && pwdata[31:5] == 27'h0
				&& pwdata[4:0] <= 5'(DHL_NUM_SRC) && pwdata[4:0] != src_r[c]) begin
				cfg_chg = 1'b1;
			end
			if (ch_maxv[c] != max_prev_r[c]) begin
				max_chg = 1'b1;
			end
		end
	end

	// clear and reset commands erase data
	assign data_clr = cfg_chg || max_chg
		|| (wr_state && (wcode == 3'(DHL_ST_CLEAR) || wcode == 3'(DHL_ST_RESET)));

	// ------------------------------------------------------------
	// motor running input, two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_sync_r <= 2'h0;
		end else begin
			run_sync_r <= {run_sync_r[0], motor_run};
		end
	end
	assign run_s = run_sync_r[1];

	// ------------------------------------------------------------
	// sampling
	// ------------------------------------------------------------
	// logging condition; an error halts logging until acknowledged
	assign log_active = !err_r && (mode_r == 3'(DHL_ST_ALWAYS)
		|| (mode_r == 3'(DHL_ST_START) && run_s));

	// one period counter shared by every channel
	dhl_tick #(
		.T0_CYC(T0_CYC),
		.T1_CYC(T1_CYC),
		.T2_CYC(T2_CYC),
		.T3_CYC(T3_CYC)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.period_sel(period_r),
		.restart(data_clr),
		.tick(tick)
	);

	genvar gc;
	generate
		for (gc = 0; gc < DHL_NUM_CH; gc++) begin : g_ch
			assign ch_en[gc] = tick && log_active && (src_r[gc] != DHL_SRC_OFF) && !data_clr;
			assign ch_sample[gc] = pick_src(src_r[gc], src_data);
			dhl_channel #(
				.BIN_W(BIN_W)
			) u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.stb(ch_en[gc]),
				.sample(ch_sample[gc]),
				.max_val(ch_maxv[gc]),
				.clr(data_clr),
				.rd_bin(rd_bin),
				.bin_cnt(ch_bin[gc]),
				.peak(ch_peak[gc])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_cmd_reset;
		wr_state && wcode == 3'(DHL_ST_RESET);
	endsequence

	sequence s_cmd_clear;
		wr_state && wcode == 3'(DHL_ST_CLEAR) && !max_chg;
	endsequence

	a_stop_no_log: assert property (mode_r == 3'(DHL_ST_STOP) |-> ch_en == '0)
		else $error("channel strobed while stopped");
	a_start_needs_run: assert property (tick && !err_r && mode_r == 3'(DHL_ST_START)
		&& !run_s |-> ch_en == '0)
		else $error("start mode logged with motor idle");
	a_reset_defaults: assert property (s_cmd_reset |=> src_r[0] == DHL_SRC_OFF
		&& src_r[3] == DHL_SRC_OFF && period_r == 2'(DHL_PER_1S)
		&& mode_r == 3'(DHL_ST_STOP) && ch_peak[0] == 16'h0)
		else $error("reset command left configuration");
	a_clear_keeps_cfg: assert property (s_cmd_clear |=> src_r[1] == $past(src_r[1])
		&& ch_peak[1] == 16'h0 && period_r == $past(period_r))
		else $error("clear command misbehaved");
	a_cfg_change_clr: assert property (cfg_chg |=> ch_peak[0] == 16'h0)
		else $error("configuration change kept data");
	a_error_readback: assert property (meas_fault && log_active |=> err_r)
		else $error("error not reported");
	a_err_code: assert property (err_r && paddr == DHL_OFF_STATE
		|-> rd_data[2:0] == 3'(DHL_ST_ERROR))
		else $error("state readback hides error");
	a_disabled_idle: assert property (src_r[0] == DHL_SRC_OFF |-> !ch_en[0])
		else $error("disabled channel sampled");
	a_common_tick: assert property (ch_en != '0 |-> tick)
		else $error("channel sampled off the common tick");
	a_period_legal: assert property (wr_period && pwdata == 32'h3 |=> period_r == 2'(DHL_PER_5S))
		else $error("period select not taken");
	a_max_floor: assert property (ch_maxv[0] >= DHL_MAX_FLOOR)
		else $error("channel maximum below floor");
endmodule

// ### distribution_histogram_logger_bench.sv
`timescale 1ns/1ns
module distribution_histogram_logger_bench import dhl_pkg::*;;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [DHL_NUM_SRC*DHL_SMP_W-1:0] src_data = '0;
	logic [DHL_NUM_CH*16-1:0] ch_max = '0;
	logic meas_fault = 1'b0;
	logic motor_run = 1'b0;
	int err_count = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic [31:0] cnt;
	logic perr;

	// 4 ns clock; tick periods shortened so a run stays short
	// four-bit bins so that saturation is reachable within a short run
	always #2 pclk = ~pclk;

	dhl_logger #(.BIN_W(4), .T0_CYC(20), .T1_CYC(100), .T2_CYC(200), .T3_CYC(500)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_data(src_data), .ch_max(ch_max),
		.meas_fault(meas_fault), .motor_run(motor_run));

	// ------------------------------------------------------------
	// bus tasks and comparisons
	// ------------------------------------------------------------
	// one apb transfer; request held until pready is seen high
	task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			$display("wrong value at %0t: pready 0x%h expected 0x1", $time, pready);
		end
	endtask

	task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
		apb_xfer(1'b1, a, d);
	endtask

	task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask

	// tick counts can shift by one against bus timing, so a window is used
	task automatic chk_range(input logic [31:0] got, input int lo, input int hi);
		total_checks++;
		if ($isunknown(got) || got < lo || got > hi) begin
			err_count++;
			$display("wrong value at %0t: got 0x%h expected 0x%h..0x%h", $time, got, lo, hi);
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb_xfer(1'b0, a, 32'h0000_0000);
		chk_eq(rd, exp);
	endtask

	function automatic logic [11:0] reg_a(input logic [11:0] base, input int idx);
		return 12'(base + 4 * idx);
	endfunction

	function automatic logic [11:0] bin_a(input int ch, input int b);
		return 12'(DHL_OFF_BIN0 + DHL_CH_STRIDE * ch + 4 * b);
	endfunction

	// all ten bins of a channel; hot names the one bin expected to hold exp
	task automatic chk_bins(input int ch, input int hot, input logic [31:0] exp);
		for (int b = 0; b < DHL_NUM_BINS; b++) begin
			rd_chk(bin_a(ch, b), (b == hot) ? exp : 32'h0000_0000);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	// watchdog well above the roughly fourteen hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		$display("wrong value at %0t: got 0x0 expected 0x1 (watchdog)", $time);
		give_verdict();
	end

	initial begin
		// sources 1..4 = 45, 100, 101, 10; channel 3 maximum below the floor
		src_data[0 +: 16] = 16'h002d;
		src_data[16 +: 16] = 16'h0064;
		src_data[32 +: 16] = 16'h0065;
		src_data[48 +: 16] = 16'h000a;
		ch_max = {16'h0064, 16'h0005, 16'h0064, 16'h0064};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;

		rd_chk(DHL_OFF_STATE, 32'h0);
		rd_chk(DHL_OFF_PERIOD, 32'h1);
		for (int c = 0; c < DHL_NUM_CH; c++) begin
			rd_chk(reg_a(DHL_OFF_SRC0, c), 32'h0);
			rd_chk(reg_a(DHL_OFF_PEAK0, c), 32'h0);
		end
		rd_chk(DHL_OFF_MAX0, 32'h64);
		rd_chk(reg_a(DHL_OFF_MAX0, 2), 32'ha);
		apb_wr(DHL_OFF_MAX0, 32'h37);
		rd_chk(DHL_OFF_MAX0, 32'h64);
		apb_xfer(1'b0, bin_a(0, 10), 32'h0);
		chk_eq({31'h0, perr}, 32'h1);
		chk_bins(0, -1, 32'h0);
		$display("test defaults done");

		for (int p = 3; p >= 0; p--) begin
			apb_wr(DHL_OFF_PERIOD, 32'(p));
			rd_chk(DHL_OFF_PERIOD, 32'(p));
		end
		apb_wr(DHL_OFF_PERIOD, 32'h7);
		rd_chk(DHL_OFF_PERIOD, 32'h0);
		$display("test period codes done");

		// channel 3 left disabled; channel 4 sees a sample above its maximum
		apb_wr(reg_a(DHL_OFF_SRC0, 0), 32'h1);
		apb_wr(reg_a(DHL_OFF_SRC0, 1), 32'h2);
		apb_wr(reg_a(DHL_OFF_SRC0, 3), 32'h3);
		apb_wr(reg_a(DHL_OFF_SRC0, 1), 32'h13);
		rd_chk(reg_a(DHL_OFF_SRC0, 1), 32'h2);
		apb_wr(DHL_OFF_STATE, 32'h2);
		repeat (200) @(posedge pclk);
		apb_wr(DHL_OFF_STATE, 32'h0);
		apb_xfer(1'b0, bin_a(0, 4), 32'h0);
		cnt = rd;
		chk_range(cnt, 8, 12);
		chk_bins(0, 4, cnt);
		chk_bins(1, 9, cnt);
		chk_bins(2, -1, 32'h0);
		chk_bins(3, -1, 32'h0);
		rd_chk(DHL_OFF_PEAK0, 32'h2d);
		rd_chk(reg_a(DHL_OFF_PEAK0, 1), 32'h64);
		$display("test always logging done");

		apb_wr(reg_a(DHL_OFF_SRC0, 0), 32'h1);
		rd_chk(bin_a(0, 4), cnt);
		apb_wr(reg_a(DHL_OFF_SRC0, 0), 32'h4);
		chk_bins(1, -1, 32'h0);
		rd_chk(reg_a(DHL_OFF_PEAK0, 1), 32'h0);
		$display("test config clear done");

		apb_wr(DHL_OFF_STATE, 32'h1);
		repeat (100) @(posedge pclk);
		rd_chk(bin_a(0, 1), 32'h0);
		@(posedge pclk);
		motor_run <= 1'b1;
		repeat (200) @(posedge pclk);
		rd_chk(DHL_OFF_STATE, 32'h1);
		apb_wr(DHL_OFF_STATE, 32'h0);
		motor_run <= 1'b0;
		apb_xfer(1'b0, bin_a(0, 1), 32'h0);
		chk_range(rd, 8, 12);
		$display("test start mode done");

		apb_wr(DHL_OFF_STATE, 32'h2);
		apb_wr(DHL_OFF_STATE, 32'h4);
		rd_chk(DHL_OFF_STATE, 32'h2);
		rd_chk(bin_a(0, 1), 32'h0);
		rd_chk(DHL_OFF_PEAK0, 32'h0);
		rd_chk(reg_a(DHL_OFF_SRC0, 0), 32'h4);
		$display("test clear command done");

		// fault raised while always mode still runs; restarting must not hide it
		apb_wr(DHL_OFF_STATE, 32'h4);
		meas_fault <= 1'b1;
		apb_wr(DHL_OFF_STATE, 32'h2);
		repeat (100) @(posedge pclk);
		meas_fault <= 1'b0;
		rd_chk(DHL_OFF_STATE, 32'h5);
		rd_chk(bin_a(0, 1), 32'h0);
		apb_wr(DHL_OFF_STATE, 32'h0);
		rd_chk(DHL_OFF_STATE, 32'h0);
		$display("test error report done");

		// about twenty ticks overfill the four-bit bins
		apb_wr(DHL_OFF_STATE, 32'h2);
		repeat (400) @(posedge pclk);
		apb_wr(DHL_OFF_STATE, 32'h0);
		rd_chk(bin_a(0, 1), 32'hf);
		rd_chk(bin_a(1, 9), 32'hf);
		$display("test saturation done");

		apb_wr(DHL_OFF_STATE, 32'h3);
		rd_chk(DHL_OFF_STATE, 32'h0);
		rd_chk(reg_a(DHL_OFF_SRC0, 0), 32'h0);
		rd_chk(reg_a(DHL_OFF_SRC0, 3), 32'h0);
		rd_chk(DHL_OFF_PERIOD, 32'h1);
		apb_wr(DHL_OFF_STATE, 32'h6);
		rd_chk(DHL_OFF_STATE, 32'h0);
		$display("test reset command done");
		give_verdict();
	end
endmodule
